/* hdl/adc_acc_params.svh */
/*
 Register offsets, field positions, reset values and timing constants for
 the converter accumulator and burst power-up control.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ADC_ACC_PARAMS_SVH
`define ADC_ACC_PARAMS_SVH

// ==========================================================
// Register map (both registers share one address, paged)
// ==========================================================
`define ACC_CONFIG_ADDR      8'hba
`define PWRUP_TIME_ADDR      8'hba
`define ACC_CONFIG_PAGE      4'h0
`define PWRUP_TIME_PAGE      4'hf
`define ACC_CONFIG_RESET     8'h00
`define PWRUP_FIELD_RESET    4'hf

// ==========================================================
// Field positions
// ==========================================================
`define ACC_EN_BIT           6
`define SJ_MSB               5
`define SJ_LSB               3
`define RPT_MSB              2
`define RPT_LSB              0
`define PWR_MSB              3
`define PWR_LSB              0

// ==========================================================
// Shift-justify codes
// ==========================================================
`define SJ_RIGHT0            3'h0
`define SJ_RIGHT1            3'h1
`define SJ_RIGHT2            3'h2
`define SJ_RIGHT2B           3'h3
`define SJ_LEFT              3'h4

// ==========================================================
// Repeat-count codes and the burst length each selects
// ==========================================================
`define RPT_CODE_1           3'h0
`define RPT_CODE_4           3'h1
`define RPT_CODE_8           3'h2
`define RPT_CODE_16          3'h3
`define RPT_CODE_32          3'h4
`define RPT_CODE_64          3'h5
`define RPT_LEN_1            7'h01
`define RPT_LEN_4            7'h04
`define RPT_LEN_8            7'h08
`define RPT_LEN_16           7'h10
`define RPT_LEN_32           7'h20
`define RPT_LEN_64           7'h40

// ==========================================================
// Timing
// ==========================================================
`define MCLK_PERIOD_NS       100
`define PWRUP_STEP_NS        400
`define PWRUP_STEP_CYC \
   ((`PWRUP_STEP_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

/* hdl/adc_acc_pkg.sv */
/*
 Types shared by the accumulator control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package adc_acc_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_POWERUP,
      ST_CONVERT
   } burst_state_type;

   typedef struct packed {
      logic       accumulate_enable;
      logic [2:0] shift_justify_select;
      logic [2:0] repeat_count;
   } acc_config_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [3:0] page;
      logic [7:0] wdata;
      logic       wr;
   } reg_req_type;

endpackage

/* hdl/adc_accumulator_burst_power.sv */
/*
 Converter accumulator and burst power-up control. Holds the accumulator
 configuration and power-up time registers, the 16-bit running sum and
 the burst sequencer. Assumes register access pulses synchronous to
 mclk_i, and a converter that pulses conv_done_i once per conversion.
*/
`timescale 1ns/1ps
`include "adc_acc_params.svh"
module adc_accumulator_burst_power
   import adc_acc_pkg::*;
#(
   parameter int ACC_W = 16,
   parameter int RES_W = 10
)
(
   // Clock and reset
   input  wire logic             mclk_i,
   input  wire logic             resetn_i,
   // Register access
   input  wire reg_req_type      req_i,
   input  wire logic             rd_i,
   input  wire logic             res_low_wr_i,
   input  wire logic             res_high_wr_i,
   input  wire logic             done_clear_i,
   // Control bits from the converter control register
   input  wire logic             burst_mode_enable_i,
   input  wire logic             converter_enable_i,
   input  wire logic             soc_i,
   // Converter
   input  wire logic             conv_done_i,
   input  wire logic [RES_W-1:0] conv_data_i,
   // Outputs
   output logic      [7:0]       rdata_o,
   output logic      [7:0]       result_low_byte_o,
   output logic      [7:0]       result_high_byte_o,
   output logic                  conversion_done_flag_o,
   output logic                  converter_power_o,
   output logic                  conv_start_o,
   output logic                  use_lp_osc_o
);

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      burst_state_type  st;
      acc_config_type   cfg;
      logic [3:0]       pwr;
      logic [ACC_W-1:0] acc;
      logic [6:0]       left;
      logic [11:0]      dly;
      logic             done;
      logic             pwr_on;
      logic             start;
      logic             lp_osc;
      logic [7:0]       rdata;
      logic [7:0]       res_lo;
      logic [7:0]       res_hi;
   } state_type;

   state_type s_q;
   state_type s_d;
   logic [ACC_W-1:0] view;
   logic [6:0]       burst_len;
   logic             cfg_hit;
   logic             pwr_hit;

   // All checks run on the system clock and sleep through reset
   default clocking cb_chk @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);

   // ==========================================================
   // Read formatting
   // ==========================================================
   result_formatter #(.WIDTH(ACC_W)) i_result_formatter
   (
      .sum_i  (s_q.acc),
      .code_i (s_q.cfg.shift_justify_select),
      .view_o (view)
   );

   always_comb
   begin
      case (s_q.cfg.repeat_count)
         `RPT_CODE_1:  burst_len = `RPT_LEN_1;
         `RPT_CODE_4:  burst_len = `RPT_LEN_4;
         `RPT_CODE_8:  burst_len = `RPT_LEN_8;
         `RPT_CODE_16: burst_len = `RPT_LEN_16;
         `RPT_CODE_32: burst_len = `RPT_LEN_32;
         `RPT_CODE_64: burst_len = `RPT_LEN_64;
         default:      burst_len = `RPT_LEN_1;
      endcase
   end

   assign cfg_hit = req_i.addr == `ACC_CONFIG_ADDR
                    && req_i.page == `ACC_CONFIG_PAGE;
   assign pwr_hit = req_i.addr == `PWRUP_TIME_ADDR
                    && req_i.page == `PWRUP_TIME_PAGE;

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb
   begin
      s_d       = s_q;
      s_d.start = 1'b0;
      // Register writes
      if (req_i.wr && cfg_hit)
      begin
         s_d.cfg.accumulate_enable    = req_i.wdata[`ACC_EN_BIT];
         s_d.cfg.shift_justify_select = req_i.wdata[`SJ_MSB:`SJ_LSB];
         s_d.cfg.repeat_count         = req_i.wdata[`RPT_MSB:`RPT_LSB];
      end
      if (req_i.wr && pwr_hit)
         s_d.pwr = req_i.wdata[`PWR_MSB:`PWR_LSB];
      // Reads: bit 6 hidden, upper power bits zero
      if (rd_i && cfg_hit)
         s_d.rdata = {2'b00, s_q.cfg.shift_justify_select,
                      s_q.cfg.repeat_count};
      else if (rd_i && pwr_hit)
         s_d.rdata = {4'h0, s_q.pwr};
      // Software writes to the pair; zero clears the running sum
      if (res_low_wr_i)
         s_d.acc[7:0] = req_i.wdata;
      if (res_high_wr_i)
         s_d.acc[ACC_W-1:8] = req_i.wdata;
      // Clear first, so a done set later in this cycle wins over it
      if (done_clear_i)
         s_d.done = 1'b0;
      s_d.lp_osc = burst_mode_enable_i;
      if (!burst_mode_enable_i)
      begin
         s_d.st     = ST_IDLE;
         s_d.pwr_on = converter_enable_i;
         if (soc_i && converter_enable_i)
            s_d.start = 1'b1;
         if (conv_done_i)
         begin
            if (s_q.cfg.accumulate_enable)
               s_d.acc = s_q.acc + ACC_W'(conv_data_i);
            else
               s_d.acc = ACC_W'(conv_data_i);
            s_d.done = 1'b1;
         end
      end
      else
      begin
         case (s_q.st)
            ST_IDLE:
            begin
               s_d.pwr_on = converter_enable_i;
               if (soc_i)
               begin
                  s_d.acc  = '0;
                  s_d.left = burst_len;
                  if (converter_enable_i)
                  begin
                     s_d.start = 1'b1;
                     s_d.st    = ST_CONVERT;
                  end
                  else
                  begin
                     s_d.pwr_on = 1'b1;
                     s_d.dly    = 12'((s_q.pwr + 5'h1)
                                  * `PWRUP_STEP_CYC);
                     s_d.st     = ST_POWERUP;
                  end
               end
            end
            ST_POWERUP:
            begin
               s_d.pwr_on = 1'b1;
               if (s_q.dly <= 12'h001)
               begin
                  s_d.start = 1'b1;
                  s_d.st    = ST_CONVERT;
               end
               else
                  s_d.dly = s_q.dly - 12'h001;
            end
            ST_CONVERT:
            begin
               s_d.pwr_on = 1'b1;
               if (conv_done_i)
               begin
                  s_d.acc  = s_q.acc + ACC_W'(conv_data_i);
                  s_d.left = s_q.left - 7'h1;
                  if (s_q.left == 7'h1)
                  begin
                     s_d.done   = 1'b1;
                     s_d.pwr_on = converter_enable_i;
                     s_d.st     = ST_IDLE;
                  end
                  else
                     s_d.start = 1'b1;
               end
            end
            default: s_d.st = ST_IDLE;
         endcase
      end
      s_d.res_lo = view[7:0];
      s_d.res_hi = view[ACC_W-1:8];
   end

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_q     <= '0;
         s_q.st  <= ST_IDLE;
         s_q.pwr <= `PWRUP_FIELD_RESET;
      end
      else
         s_q <= s_d;
   end

   assign rdata_o                = s_q.rdata;
   assign result_low_byte_o      = s_q.res_lo;
   assign result_high_byte_o     = s_q.res_hi;
   assign conversion_done_flag_o = s_q.done;
   assign converter_power_o      = s_q.pwr_on;
   assign conv_start_o           = s_q.start;
   assign use_lp_osc_o           = s_q.lp_osc;

   // ==========================================================
   // Checks
   // ==========================================================
   a_cfg_read_bit6: assert property (rd_i && cfg_hit
      |=> !rdata_o[`ACC_EN_BIT])
      else $error("accumulate enable visible on read");
   a_pwr_read_upper: assert property (rd_i && pwr_hit
      |=> rdata_o[7:4] == 4'h0)
      else $error("power register upper bits not zero");
   a_latest_result: assert property (
      conv_done_i && !burst_mode_enable_i && !s_q.cfg.accumulate_enable
      && !res_low_wr_i && !res_high_wr_i
      |=> s_q.acc == ACC_W'($past(conv_data_i)))
      else $error("result not replaced by latest conversion");
   a_sum_result: assert property (
      conv_done_i && !burst_mode_enable_i && s_q.cfg.accumulate_enable
      && !res_low_wr_i && !res_high_wr_i
      |=> s_q.acc == $past(s_q.acc) + ACC_W'($past(conv_data_i)))
      else $error("result not accumulated");
   a_power_follows: assert property (!burst_mode_enable_i
      |=> converter_power_o == $past(converter_enable_i))
      else $error("power does not follow enable");
   a_burst_immediate: assert property (
      burst_mode_enable_i && converter_enable_i && soc_i
      && s_q.st == ST_IDLE |=> conv_start_o)
      else $error("burst did not start at once");
   // Pinned at field value 2: three steps of four clocks, then the start
   a_powerup_delay: assert property (
      burst_mode_enable_i && !converter_enable_i && soc_i
      && s_q.st == ST_IDLE && s_q.pwr == 4'h2
      |=> !conv_start_o[*8] ##1 !conv_start_o[*4] ##1 conv_start_o)
      else $error("power-up delay wrong");
   a_done_sticky: assert property (
      conversion_done_flag_o && !done_clear_i |=> conversion_done_flag_o)
      else $error("done flag dropped without clear");
   a_lp_clock: assert property (
      1'b1 |=> use_lp_osc_o == $past(burst_mode_enable_i))
      else $error("clock source select wrong");

endmodule

/* hdl/result_formatter.sv */
/*
 Read-path formatter: presents the 16-bit accumulator shifted/justified.
 Assumes a stable accumulator value; purely combinational.
*/
`timescale 1ns/1ps
`include "adc_acc_params.svh"
module result_formatter
   import adc_acc_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   // Stored sum and format code
   input  wire logic [WIDTH-1:0] sum_i,
   input  wire logic [2:0]       code_i,
   // Formatted view
   output logic      [WIDTH-1:0] view_o
);

   // Left justify moves a 10-bit result to the top of the word
   localparam int LJ_SHIFT = 6;

   always_comb
   begin
      case (code_i)
         `SJ_RIGHT0:  view_o = sum_i;
         `SJ_RIGHT1:  view_o = sum_i >> 1;
         `SJ_RIGHT2,
         `SJ_RIGHT2B: view_o = sum_i >> 2;
         `SJ_LEFT:    view_o = sum_i << LJ_SHIFT;
         // Reserved codes: show the raw sum rather than garbage
         default:     view_o = sum_i;
      endcase
   end

endmodule

/* test/adc_accumulator_burst_power_tb.sv */
/*
 Self-checking bench for the accumulator and burst power-up control.
 Assumes the design package and parameter header on the include path.
*/
`timescale 1ns/1ps
`include "adc_acc_params.svh"
module adc_accumulator_burst_power_tb
   import adc_acc_pkg::*;
;
   logic        mclk_i;
   logic        resetn_i;
   reg_req_type req_i;
   logic        rd_i;
   logic        res_low_wr_i;
   logic        res_high_wr_i;
   logic        done_clear_i;
   logic        burst_mode_enable_i;
   logic        converter_enable_i;
   logic        soc_i;
   logic        conv_done_i;
   logic [9:0]  conv_data_i;
   logic [7:0]  rdata_o;
   logic [7:0]  result_low_byte_o;
   logic [7:0]  result_high_byte_o;
   logic        conversion_done_flag_o;
   logic        converter_power_o;
   logic        conv_start_o;
   logic        use_lp_osc_o;
   int          err_total;
   int          checks;
   logic [31:0] seed;
   logic [17:0] exp_q[$];
   logic        peek;
   logic        pend;
   logic [17:0] e;
   logic [15:0] sum;
   int          first;
   logic        pw;

   adc_accumulator_burst_power #(.ACC_W(16), .RES_W(10))
      i_adc_accumulator_burst_power
   (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req_i), .rd_i(rd_i),
      .res_low_wr_i(res_low_wr_i), .res_high_wr_i(res_high_wr_i),
      .done_clear_i(done_clear_i), .burst_mode_enable_i(burst_mode_enable_i),
      .converter_enable_i(converter_enable_i), .soc_i(soc_i),
      .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
      .rdata_o(rdata_o), .result_low_byte_o(result_low_byte_o),
      .result_high_byte_o(result_high_byte_o),
      .conversion_done_flag_o(conversion_done_flag_o),
      .converter_power_o(converter_power_o), .conv_start_o(conv_start_o),
      .use_lp_osc_o(use_lp_osc_o)
   );

   initial
   begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Read view of the stored sum; left justify places a 10-bit result on top
   function automatic logic [15:0] fmt(logic [15:0] v, logic [2:0] c);
      case (c)
         3'h1: return v >> 1;
         3'h2, 3'h3: return v >> 2;
         3'h4: return v << 6;
         default: return v;
      endcase
   endfunction

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic bad(string m);
      err_total++;
      $display("MISMATCH t=%0t %s", $time, m);
   endtask

   task automatic cmp_byte(logic [7:0] got, logic [7:0] exp);
      checks++;
      if (got !== exp)
         bad($sformatf("read %h expected %h", got, exp));
   endtask

   task automatic cmp_word(logic [15:0] got, logic [15:0] exp);
      checks++;
      if (got !== exp)
         bad($sformatf("result %h expected %h", got, exp));
   endtask

   task automatic cmp_flags(logic [2:0] got, logic [2:0] exp);
      checks++;
      if (got !== exp)
         bad($sformatf("flags %b expected %b", got, exp));
   endtask

   // ==========================================================
   // Drivers; rd_reg and look note their expectation for the watcher
   // ==========================================================
   task automatic wr_reg(logic [7:0] a, logic [3:0] p, logic [7:0] d);
      @(posedge mclk_i) req_i <= '{a, p, d, 1'b1};
      @(posedge mclk_i) req_i.wr <= 1'b0;
   endtask

   task automatic rd_reg(logic [7:0] a, logic [3:0] p, logic [7:0] x);
      exp_q.push_back({2'd0, 8'h00, x});
      @(posedge mclk_i) req_i <= '{a, p, 8'h00, 1'b0};
      rd_i <= 1'b1;
      @(posedge mclk_i) rd_i <= 1'b0;
   endtask

   task automatic look(logic [1:0] k, logic [15:0] x);
      exp_q.push_back({k, x});
      @(posedge mclk_i) peek <= 1'b1;
      @(posedge mclk_i) peek <= 1'b0;
   endtask

   task automatic conv(logic [9:0] d);
      @(posedge mclk_i) conv_done_i <= 1'b1;
      conv_data_i <= d;
      @(posedge mclk_i) conv_done_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
   endtask

   task automatic pulse_clear();
      @(posedge mclk_i) done_clear_i <= 1'b1;
      @(posedge mclk_i) done_clear_i <= 1'b0;
   endtask

   task automatic wait_start(output int n);
      n = 0;
      do
      begin
         @(posedge mclk_i);
         n++;
         if (n > 200)
         begin
            bad("no conversion start");
            finish_test();
         end
      end while (conv_start_o !== 1'b1);
   endtask

   // Acts as the converter: answers each start with one random result
   task automatic burst(int n);
      int          w;
      logic [9:0]  d;
      @(posedge mclk_i) soc_i <= 1'b1;
      @(posedge mclk_i) soc_i <= 1'b0;
      sum = 16'h0000;
      for (int i = 0; i < n; i++)
      begin
         wait_start(w);
         if (i == 0)
         begin
            first = w;
            pw = converter_power_o;
         end
         d = 10'(rnd());
         sum += 16'(d);
         conv_done_i <= 1'b1;
         conv_data_i <= d;
         @(posedge mclk_i) conv_done_i <= 1'b0;
      end
      repeat (8)
      begin
         @(posedge mclk_i);
         if (conv_start_o === 1'b1)
            bad("start beyond repeat count");
      end
   endtask

   // ==========================================================
   // Watcher: compares the oldest note once its result appears
   // ==========================================================
   always @(posedge mclk_i)
   begin
      if (pend)
      begin
         e = exp_q.pop_front();
         case (e[17:16])
            2'd0: cmp_byte(rdata_o, e[7:0]);
            2'd1: cmp_word({result_high_byte_o, result_low_byte_o}, e[15:0]);
            default: cmp_flags({conversion_done_flag_o, converter_power_o,
                                use_lp_osc_o}, e[2:0]);
         endcase
      end
      pend = rd_i | peek;
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial
   begin
      logic [9:0] a;
      int         cnt;
      err_total = 0;
      checks = 0;
      seed = 32'h0000_0009;
      {resetn_i, rd_i, res_low_wr_i, res_high_wr_i, done_clear_i} = 5'h00;
      {burst_mode_enable_i, converter_enable_i, soc_i, conv_done_i} = 4'h0;
      {peek, pend} = 2'b00;
      req_i = '0;
      conv_data_i = 10'h000;
      repeat (2) @(posedge mclk_i);
      resetn_i <= 1'b1;
      rd_reg(`ACC_CONFIG_ADDR, `ACC_CONFIG_PAGE, 8'h00);
      rd_reg(`PWRUP_TIME_ADDR, `PWRUP_TIME_PAGE, 8'h0f);
      wr_reg(`ACC_CONFIG_ADDR, `ACC_CONFIG_PAGE, 8'h60);
      rd_reg(`ACC_CONFIG_ADDR, `ACC_CONFIG_PAGE, 8'h20);
      wr_reg(`PWRUP_TIME_ADDR, `PWRUP_TIME_PAGE, 8'h72);
      rd_reg(`PWRUP_TIME_ADDR, `PWRUP_TIME_PAGE, 8'h02);
      // Unmapped offset must leave both registers alone
      wr_reg(8'hbb, `ACC_CONFIG_PAGE, 8'h05);
      rd_reg(`ACC_CONFIG_ADDR, `ACC_CONFIG_PAGE, 8'h20);
      converter_enable_i <= 1'b1;
      wr_reg(`ACC_CONFIG_ADDR, `ACC_CONFIG_PAGE, 8'h00);
      conv(10'(rnd()));
      a = 10'(rnd());
      conv(a);
      look(2'd1, 16'(a));
      look(2'd2, 16'h0006);
      pulse_clear();
      look(2'd2, 16'h0002);
      wr_reg(`ACC_CONFIG_ADDR, `ACC_CONFIG_PAGE, 8'h40);
      @(posedge mclk_i) req_i.wdata <= 8'h00;
      res_low_wr_i <= 1'b1;
      @(posedge mclk_i) res_low_wr_i <= 1'b0;
      res_high_wr_i <= 1'b1;
      @(posedge mclk_i) res_high_wr_i <= 1'b0;
      sum = 16'h0000;
      repeat (3)
      begin
         a = 10'(rnd());
         sum += 16'(a);
         conv(a);
      end
      look(2'd1, sum);
      // Codes above 100 are reserved and must still show the raw sum
      for (int c = 0; c < 8; c++)
      begin
         wr_reg(`ACC_CONFIG_ADDR, `ACC_CONFIG_PAGE, {2'b01, 3'(c), 3'h0});
         rd_reg(`ACC_CONFIG_ADDR, `ACC_CONFIG_PAGE, {2'b00, 3'(c), 3'h0});
         look(2'd1, fmt(sum, 3'(c)));
      end
      wr_reg(`ACC_CONFIG_ADDR, `ACC_CONFIG_PAGE, 8'h00);
      look(2'd1, sum);
      @(posedge mclk_i) converter_enable_i <= 1'b0;
      look(2'd2, 16'h0004);
      @(posedge mclk_i) burst_mode_enable_i <= 1'b1;
      converter_enable_i <= 1'b1;
      for (int r = 0; r < 6; r++)
      begin
         cnt = (r == 0) ? 1 : (4 << (r - 1));
         wr_reg(`ACC_CONFIG_ADDR, `ACC_CONFIG_PAGE, 8'(r));
         pulse_clear();
         burst(cnt);
         cmp_flags({2'b00, first == 1}, 3'h1);
         look(2'd1, sum);
         look(2'd2, 16'h0007);
      end
      // Powered down between bursts: start waits (field + 1) steps
      @(posedge mclk_i) converter_enable_i <= 1'b0;
      wr_reg(`ACC_CONFIG_ADDR, `ACC_CONFIG_PAGE, 8'h01);
      pulse_clear();
      burst(4);
      cmp_flags({2'b00, first == 3 * `PWRUP_STEP_CYC + 1}, 3'h1);
      cmp_flags({2'b00, pw}, 3'h1);
      look(2'd1, sum);
      look(2'd2, 16'h0005);
      @(posedge mclk_i) burst_mode_enable_i <= 1'b0;
      converter_enable_i <= 1'b1;
      wr_reg(`ACC_CONFIG_ADDR, `ACC_CONFIG_PAGE, 8'h00);
      look(2'd2, 16'h0006);
      repeat (4) @(posedge mclk_i);
      finish_test();
   end
endmodule
